// >>> logic/fcr_cfg.svh
// Purpose : constants for the flow-control credit read-out block
// Assumes : included by the package and the top module
// Notes   : select codes, credit ranges and read-out latencies
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH
// =====================================================================
// credit field widths
`define FCR_HDR_W       8
`define FCR_DAT_W       12
// =====================================================================
// information type select codes
`define FCR_SEL_RX_AVAIL 3'h0
`define FCR_SEL_RX_LIMIT 3'h1
`define FCR_SEL_RX_CONS  3'h2
`define FCR_SEL_TX_AVAIL 3'h4
`define FCR_SEL_TX_LIMIT 3'h5
`define FCR_SEL_TX_CONS  3'h6
// =====================================================================
// value encodings: infinite is the positive maximum, half marks sign
`define FCR_HDR_INF     8'h7F
`define FCR_DAT_INF     12'h7FF
`define FCR_HDR_HALF    8'h80
`define FCR_DAT_HALF    12'h800
`define FCR_HDR_ZERO    8'h00
`define FCR_DAT_ZERO    12'h000
// =====================================================================
// select-to-output latency per datapath width, in clock cycles
`define FCR_WIDE_DP     128
`define FCR_LAT_NARROW  2
`define FCR_LAT_WIDE    4
`endif

// >>> logic/fcr_pkg.sv
// Purpose : shared types of the flow-control credit read-out block
// Assumes : fcr_cfg.svh supplies the widths
// Notes   : a credit pair is one header count and one data count
`include "fcr_cfg.svh"
package fcr_pkg;
  // one header and one data credit count
  typedef struct packed {
    logic [`FCR_HDR_W-1:0] hdr;
    logic [`FCR_DAT_W-1:0] dat;
  } fcr_cnt_t;

  // the three credit pools
  typedef enum logic [1:0] {
    FCR_POSTED     = 2'b00,
    FCR_NONPOSTED  = 2'b01,
    FCR_COMPLETION = 2'b10
  } fcr_pool_t;

  // a one-cycle accounting event against one pool
  typedef struct packed {
    logic      valid;
    fcr_pool_t pool;
    fcr_cnt_t  amt;
  } fcr_evt_t;
endpackage : fcr_pkg

// >>> logic/fcr_info_readout.sv
// Purpose : keeps the credit counters of the three pools and reports one information type
//           at a time; also arbitrates the transmit heads by credit
// Assumes : all inputs come from logic on ref_clk; link_up_n is low while
//           the link is up; event inputs are one-cycle pulses
// Notes   : counters wrap modulo their width, as credit arithmetic does
`timescale 1ns/1ns
`include "fcr_cfg.svh"
module fcr_info_readout
  import fcr_pkg::*;
#(
  parameter int DATAPATH_W = 64
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // link state
  input  wire logic                  link_up_n,
  // advertised credits, sampled while the link is down, and infinite flags, read every cycle
  input  wire fcr_cnt_t [2:0]        local_adv,
  input  wire logic     [2:0]        local_inf,
  input  wire fcr_cnt_t [2:0]        partner_adv,
  input  wire logic     [2:0]        partner_inf,
  // accounting events
  input  wire fcr_evt_t              rx_arrive,
  input  wire fcr_evt_t              rx_drain,
  input  wire fcr_evt_t              fc_update,
  input  wire fcr_evt_t              tx_write,
  // transmit queue heads and grants
  input  wire logic                  pc_head_valid,
  input  wire fcr_pool_t             pc_head_pool,
  input  wire fcr_cnt_t              pc_head_need,
  input  wire logic                  np_head_valid,
  input  wire fcr_cnt_t              np_head_need,
  output logic                       pc_send,
  output logic                       np_send,
  // credit read-out
  input  wire logic [2:0]            credit_info_select,
  output logic [`FCR_HDR_W-1:0]      posted_header_credits,
  output logic [`FCR_DAT_W-1:0]      posted_data_credits,
  output logic [`FCR_HDR_W-1:0]      nonposted_header_credits,
  output logic [`FCR_DAT_W-1:0]      nonposted_data_credits,
  output logic [`FCR_HDR_W-1:0]      completion_header_credits,
  output logic [`FCR_DAT_W-1:0]      completion_data_credits
);

  // =====================================================================
  // constants
  // the read-out latency is fixed by the datapath width alone; user logic
  // that scans all views back to back must count the same number of edges
  localparam int LAT = (DATAPATH_W == `FCR_WIDE_DP) ? `FCR_LAT_WIDE : `FCR_LAT_NARROW;
  localparam int SD  = LAT - 1;  // select pipeline depth before the output flop

  // =====================================================================
  // reset release
  logic rst_meta_q;
  logic rst_sync_q;

  // two flops so release is clean against ref_clk; counters and the read-out
  // pipe leave reset on the same edge, so no view shows a half-released state
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // =====================================================================
  // credit counters
  fcr_cnt_t [2:0] rx_alloc_q, rx_alloc_d;  // granted to partner
  fcr_cnt_t [2:0] rx_recv_q,  rx_recv_d;   // consumed by partner
  fcr_cnt_t [2:0] tx_limit_q, tx_limit_d;  // partner limit
  fcr_cnt_t [2:0] tx_cons_q,  tx_cons_d;   // sent to partner
  fcr_cnt_t [2:0] tx_wr_q,    tx_wr_d;     // written by user
  logic           link_up;

  assign link_up = !link_up_n;

  // true when need still fits: limit - (consumed + need) mod 2^n <= half
  // the half point splits the modulo range into ahead and behind; legal
  // updates never move the limit more than half the range past consumed
  function automatic logic fcr_fits(fcr_cnt_t lim, fcr_cnt_t cons,
                                    fcr_cnt_t need, logic inf);
    logic [`FCR_HDR_W-1:0] h;
    logic [`FCR_DAT_W-1:0] d;
    h = lim.hdr - (cons.hdr + need.hdr);
    d = lim.dat - (cons.dat + need.dat);
    return inf || ((h <= `FCR_HDR_HALF) && (d <= `FCR_DAT_HALF));
  endfunction : fcr_fits

  // =====================================================================
  // transmit arbitration
  logic pc_fit;
  logic np_fit;

  // posted and completion share one ordered head, so neither passes
  // the other; a stalled head blocks whatever is queued behind it
  always_comb
  begin
    pc_fit = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (pc_head_pool == 2'(i))
        pc_fit = fcr_fits(tx_limit_q[i], tx_cons_q[i], pc_head_need,
                          partner_inf[i]);
    end
    np_fit = fcr_fits(tx_limit_q[FCR_NONPOSTED], tx_cons_q[FCR_NONPOSTED],
                      np_head_need, partner_inf[FCR_NONPOSTED]);
  end

  // the ordered head goes first; non-posted only when it is idle or stalled
  // grants are combinational so the head source pops on the same edge;
  // registering them would cost one cycle of link time per packet
  assign pc_send = link_up && pc_head_valid && pc_fit;
  assign np_send = link_up && np_head_valid && np_fit && !pc_send;

  // next counter values; while the link is down the advertised values are
  // loaded every cycle, so they are already valid when link up asserts
  always_comb
  begin
    rx_alloc_d = rx_alloc_q;
    rx_recv_d  = rx_recv_q;
    tx_limit_d = tx_limit_q;
    tx_cons_d  = tx_cons_q;
    tx_wr_d    = tx_wr_q;
    for (int i = 0; i < 3; i++)
    begin
      if (!link_up)
      begin
        rx_alloc_d[i] = local_adv[i];
        rx_recv_d[i]  = '0;
        tx_limit_d[i] = partner_adv[i];
        tx_cons_d[i]  = '0;
        tx_wr_d[i]    = '0;
      end
      else
      begin
        // amounts arrive already in credit units
        if (rx_drain.valid && rx_drain.pool == 2'(i))
        begin
          rx_alloc_d[i].hdr = rx_alloc_q[i].hdr + rx_drain.amt.hdr;
          rx_alloc_d[i].dat = rx_alloc_q[i].dat + rx_drain.amt.dat;
        end
        if (rx_arrive.valid && rx_arrive.pool == 2'(i))
        begin
          rx_recv_d[i].hdr = rx_recv_q[i].hdr + rx_arrive.amt.hdr;
          rx_recv_d[i].dat = rx_recv_q[i].dat + rx_arrive.amt.dat;
        end
        // an update carries the partner's new cumulative limit
        if (fc_update.valid && fc_update.pool == 2'(i))
          tx_limit_d[i] = fc_update.amt;
        if (tx_write.valid && tx_write.pool == 2'(i))
        begin
          tx_wr_d[i].hdr = tx_wr_q[i].hdr + tx_write.amt.hdr;
          tx_wr_d[i].dat = tx_wr_q[i].dat + tx_write.amt.dat;
        end
        if (pc_send && pc_head_pool == 2'(i))
        begin
          tx_cons_d[i].hdr = tx_cons_q[i].hdr + pc_head_need.hdr;
          tx_cons_d[i].dat = tx_cons_q[i].dat + pc_head_need.dat;
        end
        if (np_send && i == int'(FCR_NONPOSTED))
        begin
          tx_cons_d[i].hdr = tx_cons_q[i].hdr + np_head_need.hdr;
          tx_cons_d[i].dat = tx_cons_q[i].dat + np_head_need.dat;
        end
      end
    end
  end

  // counter registers
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      rx_alloc_q <= '0;
      rx_recv_q  <= '0;
      tx_limit_q <= '0;
      tx_cons_q  <= '0;
      tx_wr_q    <= '0;
    end
    else
    begin
      rx_alloc_q <= rx_alloc_d;
      rx_recv_q  <= rx_recv_d;
      tx_limit_q <= tx_limit_d;
      tx_cons_q  <= tx_cons_d;
      tx_wr_q    <= tx_wr_d;
    end
  end

  // =====================================================================
  // read-out pipeline
  logic [SD-1:0][2:0] sel_q, sel_d;
  fcr_cnt_t [2:0]     credit_q, credit_d;

  // select is simply sampled each cycle, so any cycle may change it
  // only the three select bits are delayed, cheaper than delaying all six
  // credit fields; the counters are therefore read one cycle before output
  always_comb
  begin
    sel_d[0] = credit_info_select;
    for (int k = 1; k < SD; k++)
      sel_d[k] = sel_q[k-1];
  end

  // one flop per pool, shared by all views; the last select stage picks the view
  always_comb
  begin
    credit_d = '0;
    for (int i = 0; i < 3; i++)
    begin
      unique case (sel_q[SD-1])
        `FCR_SEL_RX_AVAIL:
        begin
          // allocated minus received, wrapping modulo the field width
          credit_d[i].hdr = rx_alloc_q[i].hdr - rx_recv_q[i].hdr;
          credit_d[i].dat = rx_alloc_q[i].dat - rx_recv_q[i].dat;
        end
        `FCR_SEL_RX_LIMIT:
          credit_d[i] = local_inf[i] ? '0 : rx_alloc_q[i];
        `FCR_SEL_RX_CONS:
          credit_d[i] = rx_recv_q[i];
        `FCR_SEL_TX_AVAIL:
        begin
          if (partner_inf[i])
          begin
            credit_d[i].hdr = `FCR_HDR_INF;
            credit_d[i].dat = `FCR_DAT_INF;
          end
          else
          begin
            // written beyond the limit shows as a two's-complement negative
            credit_d[i].hdr = tx_limit_q[i].hdr - tx_wr_q[i].hdr;
            credit_d[i].dat = tx_limit_q[i].dat - tx_wr_q[i].dat;
          end
        end
        `FCR_SEL_TX_LIMIT:
          credit_d[i] = partner_inf[i] ? '0 : tx_limit_q[i];
        `FCR_SEL_TX_CONS:
          credit_d[i] = tx_cons_q[i];
        default:
          credit_d[i] = '0;
      endcase
    end
  end

  // pipeline registers
  always_ff @(posedge ref_clk or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      sel_q    <= '0;
      credit_q <= '0;
    end
    else
    begin
      sel_q    <= sel_d;
      credit_q <= credit_d;
    end
  end

  // six outputs straight from the read-out flops, so they never glitch
  // while select moves
  assign posted_header_credits     = credit_q[FCR_POSTED].hdr;
  assign posted_data_credits       = credit_q[FCR_POSTED].dat;
  assign nonposted_header_credits  = credit_q[FCR_NONPOSTED].hdr;
  assign nonposted_data_credits    = credit_q[FCR_NONPOSTED].dat;
  assign completion_header_credits = credit_q[FCR_COMPLETION].hdr;
  assign completion_data_credits   = credit_q[FCR_COMPLETION].dat;

endmodule : fcr_info_readout

// >>> tb/fcr_info_readout_props.sv
// Purpose: port-level checks of the credit read-out block
// Assumes: one clock; select latency set by DATAPATH_W
// Notes:   watches design ports only, inputs and outputs
`timescale 1ns/1ns
`include "fcr_cfg.svh"
module fcr_info_readout_props
  import fcr_pkg::*;
#(
  parameter int DATAPATH_W = 64
) (
  // clock, reset, link
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 link_up_n,
  // infinite flags, heads, grants
  input wire logic [2:0]           local_inf,
  input wire logic [2:0]           partner_inf,
  input wire logic                 pc_head_valid,
  input wire logic                 np_head_valid,
  input wire logic                 pc_send,
  input wire logic                 np_send,
  // read-out
  input wire logic [2:0]           credit_info_select,
  input wire logic [7:0]           posted_header_credits,
  input wire logic [11:0]          posted_data_credits,
  input wire logic [7:0]           nonposted_header_credits,
  input wire logic [11:0]          nonposted_data_credits,
  input wire logic [7:0]           completion_header_credits,
  input wire logic [11:0]          completion_data_credits
);
  localparam int LAT = (DATAPATH_W == `FCR_WIDE_DP) ? `FCR_LAT_WIDE : `FCR_LAT_NARROW;
  // all six outputs in pool order
  wire [59:0] outs = {posted_header_credits, posted_data_credits, nonposted_header_credits,
    nonposted_data_credits, completion_header_credits, completion_data_credits};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // =====================================
  // read-out views
  rsvd_zero_a: assert property ($past(credit_info_select, LAT) inside {3'h3, 3'h7}
    |-> outs == 60'h0) else $error("reserved select not zero");
  tx_inf_max_a: assert property ($past(credit_info_select, LAT) == 3'h4 && $past(partner_inf[1])
    |-> outs[39:20] == {`FCR_HDR_INF, `FCR_DAT_INF}) else $error("infinite not maximum");
  rx_inf_zero_a: assert property ($past(credit_info_select, LAT) == 3'h1 && $past(local_inf[2])
    |-> outs[19:0] == 20'h0_0000) else $error("rx limit not zero");
  tx_inf_zero_a: assert property ($past(credit_info_select, LAT) == 3'h5 && $past(partner_inf[1])
    |-> outs[39:20] == 20'h0_0000) else $error("tx limit not zero");
  // consumed counts reload to zero while the link is down
  rx_cons_down_a: assert property ($past(credit_info_select, LAT) == 3'h2 && $past(link_up_n)
    && $past(link_up_n, 2) |-> outs == 60'h0) else $error("rx consumed not zero");
  tx_cons_down_a: assert property ($past(credit_info_select, LAT) == 3'h6 && $past(link_up_n)
    && $past(link_up_n, 2) |-> outs == 60'h0) else $error("tx consumed not zero");
  // =====================================
  // grants
  pc_grant_a: assert property (pc_send |-> pc_head_valid && !link_up_n)
    else $error("pc grant without head");
  np_yield_a: assert property (np_send |-> np_head_valid && !pc_send && !link_up_n)
    else $error("np grant not yielding");
  cover property (pc_send);
  cover property (np_send);
  cover property (pc_head_valid && !pc_send && !link_up_n);
  cover property ($past(credit_info_select, LAT) == 3'h4 && $past(partner_inf[1]));
endmodule : fcr_info_readout_props

bind fcr_info_readout fcr_info_readout_props #(.DATAPATH_W(DATAPATH_W)) u_props (.ref_clk,
  .rst_n, .link_up_n, .local_inf, .partner_inf, .pc_head_valid, .np_head_valid, .pc_send,
  .np_send, .credit_info_select, .posted_header_credits, .posted_data_credits,
  .nonposted_header_credits, .nonposted_data_credits, .completion_header_credits,
  .completion_data_credits);

// >>> tb/fcr_user_model.sv
// Purpose: user-side transmit queue heads
// Assumes: bench loads one head at a time
// Notes:   a head pops on the cycle it is granted
`timescale 1ns/1ns
module fcr_user_model
  import fcr_pkg::*;
(
  // clock and grants
  input  wire logic     ref_clk,
  input  wire logic     pc_send,
  input  wire logic     np_send,
  // loads from the bench
  input  wire logic     pc_load,
  input  wire logic     np_load,
  input  wire fcr_cnt_t need,
  input  wire fcr_pool_t pool,
  // queue heads
  output fcr_pool_t     pc_head_pool = FCR_POSTED,
  output logic          pc_head_valid = 1'b0,
  output logic          np_head_valid = 1'b0,
  output fcr_cnt_t      pc_head_need = '0,
  output fcr_cnt_t      np_head_need = '0
);
  // a popped head shows the inverse need, so stale values never look valid
  always_ff @(posedge ref_clk)
  begin
    if (pc_load)
    begin
      {pc_head_valid, pc_head_need} <= {1'b1, need};
      pc_head_pool <= pool;
    end
    else if (pc_send) {pc_head_valid, pc_head_need} <= {1'b0, ~pc_head_need};
    if (np_load) {np_head_valid, np_head_need} <= {1'b1, need};
    else if (np_send) {np_head_valid, np_head_need} <= {1'b0, ~np_head_need};
  end
endmodule : fcr_user_model

// >>> tb/fcr_info_readout_tb.sv
// Purpose: directed scenarios for the credit read-out block
// Assumes: 64-bit datapath, two-cycle select latency
// Notes:   expected views worked out from the advertised credits
`timescale 1ns/1ns
module fcr_info_readout_tb;
  import fcr_pkg::*;
  localparam logic [59:0] L = {20'h2_009a, 20'h0_c00c, 20'h2_409a};
  localparam logic [59:0] T = {20'h0_8010, 20'h0_0000, 20'h0_4020};
  logic            ref_clk = 0, rst_n = 0, link_up_n = 1, pc_load = 0, np_load = 0;
  logic [2:0]      sel = 3'h2, local_inf = '0, partner_inf = '0;
  // the tables list the posted pool first, so the pool index runs the other way
  fcr_cnt_t [2:0]  local_adv = {L[19:0], L[39:20], L[59:40]};
  fcr_cnt_t [2:0]  partner_adv = {T[19:0], T[39:20], T[59:40]};
  fcr_evt_t        rx_arrive = '0, rx_drain = '0, fc_update = '0, tx_write = '0;
  fcr_cnt_t        need = '0, pc_need, np_need;
  fcr_pool_t       pool = FCR_POSTED, pc_pool;
  logic            pc_valid, np_valid, pc_send, np_send;
  logic [59:0]     outs;
  int              failures = 0, n_checks = 0, n_pc = 0, n_np = 0;
  // =====================================
  // clock, grant counters, design and user model
  initial forever #4 ref_clk = ~ref_clk;
  // grants are combinational, so count them mid-cycle
  always @(negedge ref_clk) {n_pc, n_np} <= {n_pc + 32'(pc_send), n_np + 32'(np_send)};
  fcr_info_readout u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .link_up_n(link_up_n),
    .local_adv(local_adv), .local_inf(local_inf), .partner_adv(partner_adv),
    .partner_inf(partner_inf), .rx_arrive(rx_arrive), .rx_drain(rx_drain),
    .fc_update(fc_update), .tx_write(tx_write), .pc_head_valid(pc_valid),
    .pc_head_pool(pc_pool), .pc_head_need(pc_need), .np_head_valid(np_valid),
    .np_head_need(np_need), .pc_send(pc_send), .np_send(np_send), .credit_info_select(sel),
    .posted_header_credits(outs[59:52]), .posted_data_credits(outs[51:40]),
    .nonposted_header_credits(outs[39:32]), .nonposted_data_credits(outs[31:20]),
    .completion_header_credits(outs[19:12]), .completion_data_credits(outs[11:0]));
  fcr_user_model u_user (.ref_clk(ref_clk), .pc_send(pc_send), .np_send(np_send),
    .pc_load(pc_load), .np_load(np_load), .need(need), .pool(pool),
    .pc_head_pool(pc_pool), .pc_head_valid(pc_valid),
    .np_head_valid(np_valid), .pc_head_need(pc_need), .np_head_need(np_need));
  // =====================================
  // shared tasks
  task automatic cmp(input logic [59:0] got, input logic [59:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic look(input logic [2:0] s, input logic [59:0] exp);
    @(posedge ref_clk);
    sel <= s;
    repeat (2) @(posedge ref_clk);
    #1;
    cmp(outs, exp);
  endtask : look
  task automatic pulse(input logic [1:0] k, input fcr_evt_t e);
    @(posedge ref_clk);
    case (k)
      2'd0: rx_arrive <= e;
      2'd1: rx_drain <= e;
      2'd2: fc_update <= e;
      default: tx_write <= e;
    endcase
    @(posedge ref_clk);
    {rx_arrive, rx_drain, fc_update, tx_write} <= '0;
  endtask : pulse
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // =====================================
  // scenarios
  task automatic t_init;
    logic [59:0] tab [8] = '{L, L, 60'h0, 60'h0, T, T, 60'h0, 60'h0};
    look(3'h6, 60'h0);
    @(posedge ref_clk);
    link_up_n <= 1'b0;
    for (int i = 0; i < 8; i++) look(3'(i), tab[i]);
  endtask : t_init
  task automatic t_rx;
    pulse(0, {1'b1, FCR_POSTED, 20'h0_1004});
    pulse(0, {1'b1, FCR_NONPOSTED, 20'h0_c00c});
    look(3'h2, {20'h0_1004, 20'h0_c00c, 20'h0_0000});
    look(3'h0, {20'h1_f096, 20'h0_0000, 20'h2_409a});
    pulse(1, {1'b1, FCR_POSTED, 20'h0_1004});
    pulse(1, {1'b1, FCR_NONPOSTED, 20'h0_c00c});
    look(3'h1, {20'h2_109e, 20'h1_8018, 20'h2_409a});
    look(3'h0, L);
  endtask : t_rx
  task automatic t_inf;
    @(posedge ref_clk);
    {partner_inf, local_inf} <= {3'b011, 3'b100};
    look(3'h4, {20'h7_f7ff, 20'h7_f7ff, 20'h0_4020});
    look(3'h5, {20'h0_0000, 20'h0_0000, 20'h0_4020});
    look(3'h1, {20'h2_109e, 20'h1_8018, 20'h0_0000});
    @(posedge ref_clk);
    {partner_inf, local_inf} <= '0;
  endtask : t_inf
  task automatic t_tx;
    pulse(3, {1'b1, FCR_POSTED, 20'h0_9000});
    look(3'h4, {20'hf_f010, 20'h0_0000, 20'h0_4020});
    look(3'h6, 60'h0);
    pulse(2, {1'b1, FCR_POSTED, 20'h0_c010});
    look(3'h5, {20'h0_c010, 20'h0_0000, 20'h0_4020});
    look(3'h4, {20'h0_3010, 20'h0_0000, 20'h0_4020});
  endtask : t_tx
  task automatic t_arb;
    // read requests go out only after checking receive space
    look(3'h0, L);
    @(posedge ref_clk);
    {np_load, need} <= {1'b1, 20'h0_1001};
    @(posedge ref_clk);
    {np_load, pc_load, need} <= {2'b01, 20'h0_1002}; // fits the partner space
    @(posedge ref_clk);
    pc_load <= 1'b0;
    repeat (6) @(posedge ref_clk);
    cmp({n_pc[29:0], n_np[29:0]}, {30'h1, 30'h0});
    cmp(60'(np_valid), 60'h1);
    pulse(2, {1'b1, FCR_NONPOSTED, 20'h0_2002});
    repeat (4) @(posedge ref_clk);
    cmp({n_pc[29:0], n_np[29:0]}, {30'h1, 30'h1});
    // a completion head short of credits holds the ordered queue
    @(posedge ref_clk);
    {pc_load, need} <= {1'b1, 20'h0_5001};
    pool <= FCR_COMPLETION;
    @(posedge ref_clk);
    pc_load <= 1'b0;
    repeat (4) @(posedge ref_clk);
    cmp({n_pc[29:0], 29'h0, pc_valid}, {30'h1, 30'h1});
    pulse(2, {1'b1, FCR_COMPLETION, 20'h0_8040});
    repeat (4) @(posedge ref_clk);
    cmp({n_pc[29:0], n_np[29:0]}, {30'h2, 30'h1});
    look(3'h6, {20'h0_1002, 20'h0_1001, 20'h0_5001});
  endtask : t_arb
  task automatic t_b2b;
    logic [2:0]  s [5] = '{3'h2, 3'h6, 3'h3, 3'h0, 3'h7};
    logic [59:0] e [5] = '{{20'h0_1004, 20'h0_c00c, 20'h0_0000},
      {20'h0_1002, 20'h0_1001, 20'h0_5001}, 60'h0, L, 60'h0};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge ref_clk);
      if (i < 5) sel <= s[i];
      #1;
      if (i >= 2) cmp(outs, e[i-2]);
    end
  endtask : t_b2b
  // =====================================
  // main sequence and watchdog
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_init();
    t_rx();
    t_inf();
    t_tx();
    t_arb();
    t_b2b();
    summarize();
  end
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    failures++;
    summarize();
  end
endmodule : fcr_info_readout_tb
